// [include/css_pkg.sv]
package css_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_KHZ    = 125000;           // 125 MHz system clock
  localparam int TICK_US    = 1000;             // Base tick of 1 ms
  localparam int TICK_CYC   = TICK_US * CLK_KHZ / 1000;
  localparam int STEP_MS    = 1;                // Thermal step hold
  localparam int STEP_CYC   = STEP_MS * TICK_CYC;
  localparam int MS_PER_MIN = 60000;
  localparam int MS_PER_HR  = 3600000;
  localparam int DBT_MIN    = 30;               // Dead-battery limit
  localparam int TOP_MIN    = 30;               // Top-off limit
  localparam int DBT_MS     = DBT_MIN * MS_PER_MIN;
  localparam int TOP_MS     = TOP_MIN * MS_PER_MIN;
  localparam int TC_HR_BASE = 5;                // Total charge 5..7 h
  localparam int POR_MS     = 250;              // Reset release delay
  localparam int POR_TICKS  = POR_MS * 1000 / TICK_US;
  // ****************************************
  // Register map and fields
  // ****************************************
  localparam logic [7:0] A_CTRL1 = 8'h00;
  localparam logic [7:0] A_CTRL2 = 8'h04;
  localparam logic [7:0] A_CTRL3 = 8'h08;
  localparam logic [7:0] A_FLAGS = 8'h0c;
  localparam logic [7:0] A_STAT  = 8'h10;
  localparam int B_CHG_EN   = 0;
  localparam int B_DBT_EN   = 1;
  localparam int B_TC_EN    = 2;
  localparam int B_TOP_EN   = 3;
  localparam int B_VREG_DIS = 4;
  localparam int B_CM_EN    = 5;
  localparam int B_SWRST    = 6;
  localparam logic [5:0] CTRL1_RST = 6'h0f;
  localparam logic [3:0] CTRL2_RST = 4'h4;      // 5 h, 7 V
  localparam logic [3:0] FC_RST    = 4'h3;
  localparam logic [3:0] LVL_MAX   = 4'hf;
  localparam int F_OVD = 0;
  localparam int F_OVR = 1;
  localparam int F_TRE = 2;
  localparam int F_TSE = 3;
  localparam int F_TRR = 4;
  localparam int F_TSR = 5;
  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic ov;
    logic t_reg;
    logic t_sd;
    logic vdroop;
    logic v35;
    logic v37;
    logic bat_abs;
    logic io14;
    logic io12;
    logic vbus_ok;
    logic above_weak;
    logic eoc;
    logic host_act;
    logic por_pin;
  } css_pins_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHG   = 3'b001,
    ST_TOP   = 3'b011,
    ST_DONE  = 3'b010,
    ST_FAULT = 3'b110
  } css_state_t;
endpackage : css_pkg

// [src/css_supervisor.sv]
`timescale 1ns/100ps
// Summary of operation
// - Dead-battery 30 min, total-charge 5..7 h, top-off 30 min timers.
// - Host enables each timer and picks total-charge hours by register.
// - Over-voltage never clears or restarts a safety timer.
// - Host alert on over-voltage start and end when battery and host up.
// - Charging halts during over-voltage and resumes once it clears.
// - Dead-battery timer keeps counting through over-voltage below weak.
// - Above 120C drop to 90 mA level, wait, then 200 mA and upward.
// - Recovery holds each current step for 1 ms before the next.
// - Above 140C charging stops entirely.
// - Flags on thermal regulation and shutdown entry and removal.
// - Temperature supervised continuously while charger is enabled.
// - Over-voltage level field 6.5..8.0 V, resets to 7 V.
// - Over-voltage detected and removed flags set on each edge.
// - Supply droop keeps lowering current; at minimum charger disabled.
// - Supply regulation on after reset; disable bit in control one.
// - Regulation off: stop below 3.5 V until steadily above 3.7 V.
// - Current monitor driven only when enabled, else pulled down.
// - Battery-absent input high disables charging at once.
// - Power-on reset low at power-up, released 250 ms after 1.4 V.
// - I/O supply below 1.2 V reasserts reset and restarts its timer.
// - Software reset leaves the power-on reset output alone.
// - Dead-battery expiry below weak threshold disables the charger.
module css_supervisor #(
  parameter int TICK_P = css_pkg::TICK_CYC,
  parameter int STEP_P = css_pkg::STEP_CYC,
  parameter int DBT_P  = css_pkg::DBT_MS,
  parameter int TOP_P  = css_pkg::TOP_MS,
  parameter int HR_P   = css_pkg::MS_PER_HR
) (
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire css_pkg::css_pins_t pins,
  output logic                   charge_on,
  output logic [3:0]             charge_level,
  output logic [1:0]             overvoltage_level_select,
  output logic                   current_monitor_enable,
  output logic                   current_monitor_pulldown,
  output logic                   host_attention,
  output logic                   por_o,
  output logic                   por_oe
);
  import css_pkg::*;

  // ****************************************
  // Input synchronisers and edge history
  // ****************************************
  css_pins_t  m_q;
  css_pins_t  p;
  css_pins_t  pp;
  // Two flops for every pin, a third only for edge detection
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      m_q <= '0;
      p   <= '0;
      pp  <= '0;
    end
    else
    begin
      m_q <= pins;
      p   <= m_q;
      pp  <= p;
    end

  // ****************************************
  // Millisecond tick divider
  // ****************************************
  logic [16:0] tick_q;
  wire         tick_w = (tick_q == 17'(TICK_P - 1));
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      tick_q <= '0;
    else
      tick_q <= tick_w ? '0 : tick_q + 17'd1;

  // ****************************************
  // APB slave
  // ****************************************
  logic [5:0]  ctrl1_q;
  logic [3:0]  ctrl2_q;
  logic [3:0]  fc_q;
  logic [5:0]  flags_q;
  logic [31:0] rd_w;
  // Two-cycle access: read data captured in the first, ready in the second
  wire acc_w  = psel & penable & ~pready;
  wire done_w = psel & penable & pready;
  wire wr_w   = done_w & pwrite;
  wire s_c1   = (paddr == A_CTRL1);
  wire s_c2   = (paddr == A_CTRL2);
  wire s_c3   = (paddr == A_CTRL3);
  wire s_fl   = (paddr == A_FLAGS);
  wire s_st   = (paddr == A_STAT);
  wire hit_w  = s_c1 | s_c2 | s_c3 | s_fl | s_st;
  // Soft reset restores settings and session, never the reset pin
  wire swrst_w = wr_w & s_c1 & pwdata[B_SWRST];

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else
    begin
      pready  <= acc_w;
      pslverr <= acc_w & ~hit_w;
      if (acc_w)
        prdata <= rd_w;
    end

  // Control registers, written at the completing edge only
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      fc_q    <= FC_RST;
    end
    else if (swrst_w)
    begin
      ctrl1_q <= CTRL1_RST;
      ctrl2_q <= CTRL2_RST;
      fc_q    <= FC_RST;
    end
    else if (wr_w)
    begin
      if (s_c1)
        ctrl1_q <= pwdata[5:0];
      if (s_c2)
        ctrl2_q <= pwdata[3:0];
      if (s_c3)
        fc_q <= pwdata[3:0];
    end

  wire chg_en   = ctrl1_q[B_CHG_EN];
  wire dbt_en   = ctrl1_q[B_DBT_EN];
  wire tc_en    = ctrl1_q[B_TC_EN];
  wire top_en   = ctrl1_q[B_TOP_EN];
  wire vreg_dis = ctrl1_q[B_VREG_DIS];
  assign overvoltage_level_select = ctrl2_q[3:2];
  assign current_monitor_enable   = ctrl1_q[B_CM_EN];

  // ****************************************
  // Charge session state
  // ****************************************
  css_state_t st_q;
  css_state_t st_d;
  logic [24:0] dbt_q;
  logic [24:0] tc_q;
  logic [24:0] top_q;
  logic [3:0]  lvl_q;
  logic [3:0]  dr_q;
  logic        uv_q;
  logic        dip_q;
  wire sess_clr = ~chg_en | ~p.vbus_ok | swrst_w;
  wire active_w = (st_q == ST_CHG) | (st_q == ST_TOP);
  wire vreg_act = ~vreg_dis & active_w;
  // Limits; a code of 3 hours selects the longest, 7 h
  wire [1:0]  hr_w   = (ctrl2_q[1:0] > 2'd2) ? 2'd2 : ctrl2_q[1:0];
  wire [24:0] tc_lim = 25'((TC_HR_BASE + int'(hr_w)) * HR_P);
  wire dbt_exp = (dbt_q == 25'(DBT_P));
  wire tc_exp  = (tc_q == tc_lim);
  wire top_exp = (top_q == 25'(TOP_P));
  // Dead-battery count ignores over-voltage on purpose
  wire dbt_run = (st_q == ST_CHG) & dbt_en & ~p.above_weak
               & ~dbt_exp;
  wire tc_run  = (st_q == ST_CHG) & tc_en & ~p.ov & ~tc_exp;
  wire top_run = (st_q == ST_TOP) & ~p.ov & ~top_exp;
  wire dr_fault = vreg_act & p.vdroop & tick_w
                & (dr_q == 4'h0);
  wire fault_w = (dbt_exp & ~p.above_weak)
               | tc_exp | dr_fault;
  // Stop sources; any one holds the charger off while present
  wire halt_w = p.ov
              | p.t_sd
              | p.bat_abs
              | uv_q;

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        st_d = (chg_en & p.vbus_ok) ? ST_CHG : ST_IDLE;
      ST_CHG:
        if (p.eoc)
          st_d = top_en ? ST_TOP : ST_DONE;
      ST_TOP:
        if (top_exp | ~top_en)
          st_d = ST_DONE;
      ST_DONE:
        st_d = ST_DONE;
      ST_FAULT:
        st_d = ST_FAULT;
      default:
        st_d = ST_IDLE;
    endcase
    if (active_w & fault_w)
      st_d = ST_FAULT;
    if (sess_clr)
      st_d = ST_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      st_q <= ST_IDLE;
    else
      st_q <= st_d;

  // Safety timers count ms ticks; only the session end clears them
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      dbt_q <= '0;
      tc_q  <= '0;
      top_q <= '0;
    end
    else if (sess_clr)
    begin
      dbt_q <= '0;
      tc_q  <= '0;
      top_q <= '0;
    end
    else if (tick_w)
    begin
      if (dbt_run)
        dbt_q <= dbt_q + 25'd1;
      if (tc_run)
        tc_q <= tc_q + 25'd1;
      if (top_run)
        top_q <= top_q + 25'd1;
    end

  // ****************************************
  // Thermal regulation stepping
  // ****************************************
  logic [16:0] step_q;
  wire treg_w  = p.t_reg & chg_en;
  wire step_dn = (step_q == 17'(STEP_P - 1));
  // Step timer restarts on every drop so each level lasts a full 1 ms
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      lvl_q  <= '0;
      step_q <= '0;
    end
    else if (treg_w)
    begin
      lvl_q  <= 4'h0;
      step_q <= '0;
    end
    else if (lvl_q < fc_q)
    begin
      step_q <= step_dn ? '0 : step_q + 17'd1;
      if (step_dn)
        lvl_q <= lvl_q + 4'd1;
    end
    else
    begin
      lvl_q  <= fc_q;
      step_q <= '0;
    end

  // ****************************************
  // Supply droop and undervoltage
  // ****************************************
  // Droop trims one level per tick and relaxes one per quiet tick
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      dr_q <= LVL_MAX;
    else if (~vreg_act)
      dr_q <= LVL_MAX;
    else if (tick_w & p.vdroop & (dr_q != 4'h0))
      dr_q <= dr_q - 4'd1;
    else if (tick_w & ~p.vdroop & (dr_q != LVL_MAX))
      dr_q <= dr_q + 4'd1;

  // Release needs a whole tick above 3.7 V, so a bounce holds it off
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      uv_q  <= 1'b0;
      dip_q <= 1'b0;
    end
    else
    begin
      dip_q <= ~p.v37 | (dip_q & ~tick_w);
      if (~vreg_dis)
        uv_q <= 1'b0;
      else if (~p.v35)
        uv_q <= 1'b1;
      else if (tick_w & ~dip_q & p.v37)
        uv_q <= 1'b0;
    end

  // ****************************************
  // Event flags, write one to clear
  // ****************************************
  logic [5:0] set_w;
  always_comb
  begin
    set_w        = '0;
    set_w[F_OVD] = p.ov & ~pp.ov;
    set_w[F_OVR] = ~p.ov & pp.ov;
    set_w[F_TRE] = chg_en & p.t_reg & ~pp.t_reg;
    set_w[F_TSE] = chg_en & p.t_sd & ~pp.t_sd;
    set_w[F_TRR] = chg_en & ~p.t_reg & pp.t_reg;
    set_w[F_TSR] = chg_en & ~p.t_sd & pp.t_sd;
  end
  wire [5:0] clr_w = (wr_w & s_fl) ? pwdata[5:0] : 6'h00;

  // A new event in the clearing cycle survives the clear
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
      flags_q <= '0;
    else if (swrst_w)
      flags_q <= set_w;
    else
      flags_q <= (flags_q & ~clr_w) | set_w;

  // ****************************************
  // Outputs
  // ****************************************
  wire [3:0] lvl_w = (lvl_q < dr_q) ? lvl_q : dr_q;
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      charge_on                <= 1'b0;
      charge_level             <= '0;
      current_monitor_pulldown <= 1'b1;
      host_attention           <= 1'b0;
    end
    else
    begin
      charge_on    <= active_w & ~halt_w & ~fault_w;
      charge_level <= lvl_w;
      current_monitor_pulldown <= ~ctrl1_q[B_CM_EN];
      host_attention <= (|flags_q[1:0]) & p.above_weak
                      & p.host_act;
    end

  // ****************************************
  // Power-on reset pin, outside soft reset
  // ****************************************
  logic [7:0] por_q;
  wire por_dn = (por_q == 8'(POR_TICKS - 1));
  // Open drain: output stays low, enable high pulls the pin down
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      por_oe <= 1'b1;
      por_o  <= 1'b0;
      por_q  <= '0;
    end
    else if (~p.io12)
    begin
      por_oe <= 1'b1;
      por_q  <= '0;
    end
    else if (por_oe & p.io14 & tick_w)
    begin
      por_q <= por_dn ? por_q : por_q + 8'd1;
      if (por_dn)
        por_oe <= 1'b0;
    end

  // Read mux
  always_comb
  begin
    rd_w = '0;
    case (1'b1)
      s_c1: rd_w[5:0] = ctrl1_q;
      s_c2: rd_w[3:0] = ctrl2_q;
      s_c3: rd_w[3:0] = fc_q;
      s_fl: rd_w[5:0] = flags_q;
      s_st: rd_w[17:0] = {p.por_pin, p.ov, p.t_reg, p.t_sd,
                          dbt_exp, tc_exp, top_exp, uv_q,
                          dr_q, lvl_q, charge_on, st_q == ST_FAULT};
      default: rd_w = '0;
    endcase
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  ov_halt_a: assert property (p.ov |=> !charge_on)
    else $error("charging during over-voltage");
  tsd_halt_a: assert property (p.t_sd |=> !charge_on)
    else $error("charging during thermal shutdown");
  bat_off_a: assert property (p.bat_abs |=> !charge_on)
    else $error("charging without battery");
  ov_flag_a: assert property ($rose(p.ov) |=> flags_q[F_OVD])
    else $error("over-voltage flag not set");
  tc_keep_a: assert property (p.ov && !sess_clr |=> $stable(tc_q))
    else $error("total timer moved during over-voltage");
  dbt_run_a: assert property
    (dbt_run && tick_w && !sess_clr |=> dbt_q == $past(dbt_q) + 25'd1)
    else $error("dead-battery timer stalled");
  treg_drop_a: assert property (treg_w |=> lvl_q == 4'h0)
    else $error("no drop on thermal regulation");
  step_hold_a: assert property
    (lvl_q > $past(lvl_q) |-> $past(step_dn))
    else $error("step advanced early");
  top_hold_a: assert property
    (lvl_q == fc_q && !treg_w && $stable(fc_q)
     |=> lvl_q == $past(fc_q))
    else $error("programmed level not held");
  por_low_a: assert property (!p.io12 |=> por_oe && por_q == 8'h00)
    else $error("reset not reasserted");
endmodule : css_supervisor

// [tb/css_host.sv]
`timescale 1ns/100ps
// Baseband host model: APB master that software uses to reach registers
module css_host (
  input  wire logic        clk_sys,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // Timer enables, monitor enable and hours all go through this transfer
  // Request is held until pready is sampled high, never released early
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
      @(posedge clk_sys);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~d;
  endtask : xfer
endmodule : css_host

// [tb/tb_css_supervisor.sv]
`timescale 1ns/100ps
// Bench: short timing parameters keep long safety counts affordable
module tb_css_supervisor;
  import css_pkg::*;
  localparam int LIMIT = 20000;
  logic        clk_sys, rstn, psel, penable, pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, charge_on;
  logic [3:0]  charge_level;
  logic [1:0]  ovl;
  logic        cm_en, cm_pd, host_attention, por_o, por_oe;
  css_pins_t   pins;
  int          miscompares = 0;
  int          n_compared = 0;
  int          n_cyc = 0;

  css_supervisor #(.TICK_P(10), .STEP_P(10), .DBT_P(20), .TOP_P(20),
                   .HR_P(10)) u_dut (
    .clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pins, .charge_on, .charge_level,
    .overvoltage_level_select(ovl), .current_monitor_enable(cm_en),
    .current_monitor_pulldown(cm_pd), .host_attention, .por_o, .por_oe
  );

  css_host u_host (
    .clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr
  );

  // ****************************************
  // Bench plumbing
  // ****************************************
  always #4 clk_sys = ~clk_sys;

  // Hang guard: a stuck wait ends in the closing report
  always @(posedge clk_sys)
  begin
    n_cyc <= n_cyc + 1;
    if (n_cyc == LIMIT)
    begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc

  task automatic con(input logic x);
    chk(32'(charge_on), 32'(x));
  endtask : con

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    u_host.xfer(1'b1, a, d, r, e);
  endtask : wr

  // Read, compare masked data, and expect an error only above A_STAT
  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    u_host.xfer(1'b0, a, 32'h0, r, e);
    chk(r & m, x);
    chk(32'(e), 32'(a > A_STAT));
  endtask : rdm

  // Fresh session: disabling first clears any latched fault
  task automatic start(input logic [7:0] c);
    wr(A_CTRL1, 32'h0);
    wr(A_CTRL1, {24'h0, c});
    wr(A_FLAGS, 32'h3f);
    cyc(5);
  endtask : start

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rdm(A_CTRL1, 32'hff, 32'h0f);
    rdm(A_CTRL2, 32'hff, 32'h04);
    rdm(A_CTRL3, 32'hff, 32'h03);
    chk(32'(ovl), 32'h1);
    chk(32'(cm_pd), 32'h1);
    chk(32'(cm_en), 32'h0);
    wr(8'h20, 32'h0);
    rdm(8'h14, 32'hffffffff, 32'h0);
    rdm(A_CTRL1, 32'hff, 32'h0f);
  endtask : t_reset

  task automatic t_por();
    chk(32'(por_oe), 32'h1);
    chk(32'(por_o), 32'h0);
    cyc(2300);
    chk(32'(por_oe), 32'h1);
    cyc(400);
    chk(32'(por_oe), 32'h0);
    wr(A_CTRL1, 32'h40);
    cyc(5);
    chk(32'(por_oe), 32'h0);
    pins.io12 <= 1'b0;
    cyc(5);
    chk(32'(por_oe), 32'h1);
    pins.io12 <= 1'b1;
    cyc(2400);
    chk(32'(por_oe), 32'h1);
    cyc(200);
    chk(32'(por_oe), 32'h0);
  endtask : t_por

  task automatic t_ov();
    start(8'h01);
    con(1'b1);
    pins.ov <= 1'b1;
    cyc(5);
    con(1'b0);
    chk(32'(host_attention), 32'h1);
    rdm(A_FLAGS, 32'h3f, 32'h01);
    pins.ov <= 1'b0;
    cyc(5);
    con(1'b1);
    rdm(A_FLAGS, 32'h3f, 32'h03);
    wr(A_FLAGS, 32'h03);
    cyc(3);
    chk(32'(host_attention), 32'h0);
    pins.host_act <= 1'b0;
    pins.ov <= 1'b1;
    cyc(5);
    chk(32'(host_attention), 32'h0);
    pins.ov <= 1'b0;
    pins.host_act <= 1'b1;
    cyc(5);
  endtask : t_ov

  // Hot pulse shorter than one step, then watch the 1 ms staircase
  task automatic t_therm();
    start(8'h01);
    pins.t_reg <= 1'b1;
    cyc(4);
    pins.t_reg <= 1'b0;
    cyc(4);
    for (int i = 0; i < 4; i++)
    begin
      chk(32'(charge_level), i);
      cyc(10);
    end
    cyc(40);
    chk(32'(charge_level), 32'h3);
    rdm(A_FLAGS, 32'h3f, 32'h14);
    pins.t_sd <= 1'b1;
    cyc(5);
    con(1'b0);
    pins.t_sd <= 1'b0;
    cyc(5);
    rdm(A_FLAGS, 32'h28, 32'h28);
  endtask : t_therm

  task automatic t_supply();
    start(8'h01);
    pins.vdroop <= 1'b1;
    cyc(180);
    con(1'b0);
    rdm(A_STAT, 32'h1, 32'h1);
    start(8'h11);
    cyc(80);
    con(1'b1);
    pins.v35 <= 1'b0;
    pins.v37 <= 1'b0;
    cyc(5);
    con(1'b0);
    pins.v35 <= 1'b1;
    pins.v37 <= 1'b1;
    cyc(4);
    con(1'b0);
    cyc(30);
    con(1'b1);
    pins.vdroop <= 1'b0;
  endtask : t_supply

  task automatic t_misc();
    start(8'h21);
    chk(32'(cm_en), 32'h1);
    chk(32'(cm_pd), 32'h0);
    pins.bat_abs <= 1'b1;
    cyc(4);
    con(1'b0);
    pins.bat_abs <= 1'b0;
    cyc(5);
    con(1'b1);
    // Top-off runs after end of charge, then stops on its own limit
    start(8'h09);
    pins.eoc <= 1'b1;
    cyc(150);
    con(1'b1);
    cyc(100);
    con(1'b0);
    rdm(A_STAT, 32'h800, 32'h800);
    pins.eoc <= 1'b0;
  endtask : t_misc

  // Over-voltage in mid-count must not stretch the dead-battery limit
  task automatic t_dead();
    pins.above_weak <= 1'b0;
    start(8'h03);
    cyc(100);
    pins.ov <= 1'b1;
    cyc(50);
    pins.ov <= 1'b0;
    cyc(25);
    con(1'b1);
    cyc(50);
    con(1'b0);
    rdm(A_STAT, 32'h2000, 32'h2000);
    pins.above_weak <= 1'b1;
  endtask : t_dead

  task automatic t_total();
    for (int i = 0; i < 4; i++)
    begin
      wr(A_CTRL2, 32'(i * 4 + 2));
      cyc(2);
      chk(32'(ovl), i);
    end
    start(8'h05);
    cyc(640);
    con(1'b1);
    cyc(100);
    con(1'b0);
    start(8'h01);
    cyc(760);
    con(1'b1);
    // Shortest hour code must end the session well before the longest
    wr(A_CTRL2, 32'h4);
    start(8'h05);
    cyc(430);
    con(1'b1);
    cyc(100);
    con(1'b0);
  endtask : t_total

  // Main sequence: every input defined at time zero, then reset
  initial
  begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    pins = '0;
    pins.v35 = 1'b1;
    pins.v37 = 1'b1;
    pins.io14 = 1'b1;
    pins.io12 = 1'b1;
    pins.vbus_ok = 1'b1;
    pins.above_weak = 1'b1;
    pins.host_act = 1'b1;
    cyc(10);
    rstn <= 1'b1;
    t_reset();
    t_por();
    t_ov();
    t_therm();
    t_supply();
    t_misc();
    t_dead();
    t_total();
    stop_test();
  end
endmodule : tb_css_supervisor
